//--- adc_parallel_host_port_tb.sv
// Self-checking bench of the host port
`timescale 1ns/1ps
`default_nettype none
`include "ahp_regs.svh"
module adc_parallel_host_port_tb;
	import ahp_pkg::*;
	logic i_clk_sys;
	logic i_reset;
	logic cs_a_n;
	logic cs_b;
	logic rd_n;
	logic st_n;
	logic oe;
	logic flag;
	logic res_valid;
	logic res_ready;
	logic comb;
	logic dev_rst;
	logic [11:0] bus_w;
	logic [11:0] bus_r;
	logic [9:0] res_word;
	logic [9:0] cr0;
	logic [9:0] cr1;
	ahp_state_t state;
	int errors;
	int compares;
	ahp_host_port i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_chip_sel_a_n(cs_a_n),
		.i_chip_sel_b(cs_b), .i_read_n(rd_n), .i_store_n(st_n), .i_data(bus_w),
		.o_data(bus_r), .o_data_oe(oe), .o_result_ready_flag(flag), .i_result_valid(res_valid),
		.o_result_ready(res_ready), .i_result_word(res_word), .o_ctrl_reg0(cr0),
		.o_ctrl_reg1(cr1), .o_combined_mode(comb), .o_device_reset(dev_rst), .o_state(state));
	ahp_host_model i_host (.i_clk_sys(i_clk_sys), .i_data(bus_r), .i_data_oe(oe),
		.o_chip_sel_a_n(cs_a_n),
		.o_chip_sel_b(cs_b), .o_read_n(rd_n), .o_store_n(st_n), .o_data(bus_w));
	// Clock
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic push(input logic [9:0] w);
		logic r;
		@(posedge i_clk_sys);
		res_valid <= 1'b1;
		res_word <= w;
		do begin
			@(negedge i_clk_sys) r = res_ready;
			@(posedge i_clk_sys);
		end while (!r);
		res_valid <= 1'b0;
	endtask
	task automatic t_reset;
		chk(cr0, 12'h000);
		chk(cr1, 12'h030);
		chk({oe, flag, comb, dev_rst, res_ready, state}, 12'h004);
	endtask
	// Fill until refused, then drain by separate-strobe reads
	task automatic t_fifo;
		for (int i = 0; i < 16; i++) push(10'h200 + i[9:0]);
		@(negedge i_clk_sys);
		chk(res_ready, 1'b0);
		chk(flag, 1'b1);
		for (int i = 0; i < 16; i++) begin
			i_host.access(1'b0, 1'b1, 12'h000, 1'b0);
			chk(i_host.rd_word, 12'h200 + i[11:0]);
		end
		chk(flag, 1'b0);
		i_host.access(1'b0, 1'b1, 12'h000, 1'b0);
		chk(i_host.rd_word, 12'h20f);
		chk(oe, 1'b0);
		i_host.access(1'b0, 1'b0, 12'h0ff, 1'b0);
		chk(cr0, 12'h000);
	endtask
	task automatic t_write;
		i_host.access(1'b1, 1'b0, 12'h0a5, 1'b0);
		chk(cr0, 12'h0a5);
		i_host.access(1'b1, 1'b0, 12'h8ff, 1'b0);
		chk({cr1, 2'h0} ^ cr0, {10'h030, 2'h0} ^ 12'h0a5);
		i_host.access(1'b1, 1'b0, 12'h470, 1'b0);
		chk({comb, cr1}, 12'h470);
	endtask
	task automatic t_comb;
		push(10'h155);
		i_host.access(1'b1, 1'b1, 12'h000, 1'b1);
		chk(i_host.rd_word, 12'h155);
		i_host.access(1'b1, 1'b0, 12'h033, 1'b0);
		chk(cr0, 12'h033);
		i_host.access(1'b1, 1'b0, 12'h431, 1'b0);
		chk({dev_rst, comb, cr1}, 12'h831);
		chk(cr0, 12'h000);
		i_host.access(1'b1, 1'b0, 12'h430, 1'b0);
		chk({dev_rst, comb, cr1}, 12'h030);
	endtask
	task automatic end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		i_reset = 1'b1;
		res_valid = 1'b0;
		res_word = 10'h000;
		errors = 0;
		compares = 0;
		repeat (6) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		t_reset();
		t_fifo();
		t_write();
		t_comb();
		end_of_test();
	end
	// Watchdog, several times the expected run
	initial begin
		#50000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire

//--- ahp_fifo.sv
// Result word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ahp_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Handshakes
	assign o_in_ready = (count != DEPTH[AW:0]);
	assign o_out_valid = (count != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr];

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	// Word array write
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- ahp_host_model.sv
// Host bus model driving the port pins
`timescale 1ns/1ps
`default_nettype none
`include "ahp_regs.svh"
module ahp_host_model (
	input wire logic i_clk_sys,
	input wire logic [`AHP_BUS_W-1:0] i_data,
	input wire logic i_data_oe,
	output logic o_chip_sel_a_n,
	output logic o_chip_sel_b,
	output logic o_read_n,
	output logic o_store_n,
	output logic [`AHP_BUS_W-1:0] o_data
);
	logic sample_clock;
	logic [`AHP_BUS_W-1:0] rd_word;
	// Free-running sample clock, 160 ns period
	initial begin
		sample_clock = 1'b1;
		forever #80 sample_clock = ~sample_clock;
	end
	// Idle pins
	initial begin
		o_chip_sel_a_n = 1'b1;
		o_chip_sel_b = 1'b0;
		o_read_n = 1'b1;
		o_store_n = 1'b1;
		o_data = 12'h000;
		rd_word = 12'h000;
	end
	// One access, low select last and released first
	task automatic access(input logic rn, input logic sn, input logic [11:0] wd, input bit al);
		if (al) begin
			@(negedge sample_clock);
			#20;
		end
		@(posedge i_clk_sys);
		o_chip_sel_b <= 1'b1;
		o_store_n <= sn;
		o_data <= wd;
		@(posedge i_clk_sys);
		o_chip_sel_a_n <= 1'b0;
		o_read_n <= rn;
		repeat (6) @(posedge i_clk_sys);
		// Drivers off read back as the inverse, so a stale word cannot pass
		rd_word = i_data_oe ? i_data : ~i_data;
		o_chip_sel_a_n <= 1'b1;
		@(posedge i_clk_sys);
		o_chip_sel_b <= 1'b0;
		o_store_n <= 1'b1;
		o_read_n <= 1'b1;
		o_data <= ~wd;
		repeat (5) @(posedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

//--- ahp_host_port.sv
// Parallel host port of a four-input sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "ahp_regs.svh"
module ahp_host_port (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Host bus pins
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_read_n,
	input wire logic i_store_n,
	input wire logic [`AHP_BUS_W-1:0] i_data,
	output logic [`AHP_BUS_W-1:0] o_data,
	output logic o_data_oe,
	output logic o_result_ready_flag,
	// Converter result stream
	input wire logic i_result_valid,
	output logic o_result_ready,
	input wire logic [`AHP_RESULT_W-1:0] i_result_word,
	// Control outputs to the converter core
	output logic [`AHP_CTRL_W-1:0] o_ctrl_reg0,
	output logic [`AHP_CTRL_W-1:0] o_ctrl_reg1,
	output logic o_combined_mode,
	output logic o_device_reset,
	output ahp_pkg::ahp_state_t o_state
);
	import ahp_pkg::*;

	localparam int FLAG_CNT_W = 4;
	localparam logic [FLAG_CNT_W-1:0] FLAG_DELAY = FLAG_CNT_W'(`AHP_FLAG_DELAY_CYC);

	logic cs_a_n_s;
	logic cs_b_s;
	logic read_n_s;
	logic store_n_s;
	logic [`AHP_BUS_W-1:0] data_s;
	logic [`AHP_CTRL_W-1:0] ctrl_reg0;
	logic [`AHP_CTRL_W-1:0] ctrl_reg1;
	logic combined;
	logic selected;
	logic read_qual;
	logic write_qual;
	ahp_state_t state;
	ahp_state_t next_state;
	logic [`AHP_BUS_W-1:0] write_hold;
	logic fifo_valid;
	logic fifo_pop;
	logic [`AHP_RESULT_W-1:0] fifo_word;
	logic [FLAG_CNT_W-1:0] flag_cnt;
	logic flag;
	logic [`AHP_BUS_W-1:0] out_word;
	logic read_start;
	logic write_end;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Result word widened to the bus, top bits zero
	function automatic logic [`AHP_BUS_W-1:0] pad_result(input logic [`AHP_RESULT_W-1:0] w);
		pad_result = {{(`AHP_BUS_W - `AHP_RESULT_W){1'b0}}, w};
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Strobes idle inactive after reset: selects off, both strobes high
	// Every pin passes two stages before the decode reads it
	ahp_sync #(
		.WIDTH(4),
		.INIT(4'hb)
	) u_strobe_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_async({i_chip_sel_a_n, i_chip_sel_b, i_read_n, i_store_n}),
		.o_sync({cs_a_n_s, cs_b_s, read_n_s, store_n_s})
	);

	// Bus data lags with the strobes by the same two stages
	// Same depth keeps the held word aligned with the write qualifier
	ahp_sync #(
		.WIDTH(`AHP_BUS_W),
		.INIT('0)
	) u_data_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_async(i_data),
		.o_sync(data_s)
	);

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	// Mode bit turns the store strobe into a direction input
	// A mode change takes hold only after the write that set it has closed
	assign combined = ctrl_reg1[`AHP_CR1_MODE_BIT];
	assign selected = !cs_a_n_s && cs_b_s;

	// Read and write qualifiers, both levels of their inputs
	// Decode sees synced pins only, so an edge near the clock cannot split an access
	always_comb begin
		if (combined) begin
			// Read strobe ignored, direction high reads, low writes
			read_qual = selected && store_n_s;
			write_qual = selected && !store_n_s;
		end else begin
			read_qual = selected && !read_n_s && store_n_s;
			write_qual = selected && !store_n_s && read_n_s;
		end
	end

	// ---------------------------------------------------------------
	// Access state
	// ---------------------------------------------------------------
	// Pulse lasts as long as its qualifier, one cycle less if that rises as the other one falls
	always_comb begin
		next_state = state;
		case (state)
			AHP_IDLE: begin
				if (read_qual) begin
					next_state = AHP_READ;
				end else if (write_qual) begin
					next_state = AHP_WRITE;
				end
			end
			AHP_READ: begin
				if (!read_qual) begin
					next_state = AHP_IDLE;
				end
			end
			AHP_WRITE: begin
				if (!write_qual) begin
					next_state = AHP_IDLE;
				end
			end
			default: begin
				next_state = AHP_IDLE;
			end
		endcase
	end

	// State register
	// One bit moves on each step of the usual path
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state <= AHP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign o_state = state;

	// Single-cycle marks of a read opening and a write closing
	assign read_start = (state == AHP_IDLE) && (next_state == AHP_READ);
	assign write_end = (state == AHP_WRITE) && (next_state != AHP_WRITE);

	// ---------------------------------------------------------------
	// Result path
	// ---------------------------------------------------------------
	// Result words wait here until the host reads them
	// Converter side pushes on valid and ready, on the system clock
	// A full FIFO refuses new words rather than overwrite unread ones
	ahp_fifo #(
		.WIDTH(`AHP_RESULT_W),
		.DEPTH(`AHP_FIFO_DEPTH)
	) u_result_fifo (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_in_valid(i_result_valid),
		.o_in_ready(o_result_ready),
		.i_in_data(i_result_word),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_word)
	);

	// One word taken as each read begins, so one read never takes two
	assign fifo_pop = read_start;

	// Output word register, holds last word if nothing new
	// An empty FIFO thus shows the previous word again on a further read
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			out_word <= '0;
		end else if (fifo_pop && fifo_valid) begin
			out_word <= pad_result(fifo_word);
		end
	end

	// Drivers on only during the read, off with the first inactive input
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_data_oe <= 1'b0;
		end else begin
			o_data_oe <= (next_state == AHP_READ);
		end
	end

	// Bus word: the fresh result at a read opening, else the last one shown
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_data <= '0;
		end else if (fifo_pop && fifo_valid) begin
			o_data <= pad_result(fifo_word);
		end else begin
			o_data <= out_word;
		end
	end

	// ---------------------------------------------------------------
	// Data-available flag
	// ---------------------------------------------------------------
	// Flag drops a fixed delay after the read starts
	// A load of zero gives a drop one cycle after the read opens
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			flag_cnt <= '0;
		end else if (fifo_pop) begin
			flag_cnt <= FLAG_DELAY - 1'b1;
		end else if (flag_cnt != '0) begin
			flag_cnt <= flag_cnt - 1'b1;
		end
	end

	// Flag follows waiting words outside reads
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			flag <= 1'b0;
		end else if ((state == AHP_READ) && (flag_cnt == '0)) begin
			flag <= 1'b0;
		end else if (state != AHP_READ) begin
			flag <= fifo_valid;
		end
	end

	assign o_result_ready_flag = flag;

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	// Bus word tracked while the write is active
	// Tracking each cycle keeps the last word set up before the strobe end
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			write_hold <= '0;
		end else if (write_qual && (state != AHP_READ)) begin
			write_hold <= data_s;
		end
	end

	// Commit at the end of the write pulse
	// Late commit lets a word that settles during the pulse still land
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ctrl_reg0 <= `AHP_CR0_RESET;
			ctrl_reg1 <= `AHP_CR1_RESET;
		end else if (write_end) begin
			case (write_hold[`AHP_SEL_HI:`AHP_SEL_LO])
				`AHP_SEL_CR0: begin
					ctrl_reg0 <= write_hold[`AHP_CTRL_W-1:0];
				end
				`AHP_SEL_CR1: begin
					if (write_hold[`AHP_CR1_RESET_BIT]) begin
						// Reset bit restores both, stays set until cleared
						ctrl_reg0 <= `AHP_CR0_RESET;
						ctrl_reg1 <= `AHP_CR1_RESET | `AHP_CTRL_W'(1);
					end else begin
						ctrl_reg1 <= write_hold[`AHP_CTRL_W-1:0];
					end
				end
				// Unknown selects leave both registers as they were
				default: begin
					ctrl_reg0 <= ctrl_reg0;
				end
			endcase
		end
	end

	// Register contents and mode to the converter core
	assign o_ctrl_reg0 = ctrl_reg0;
	assign o_ctrl_reg1 = ctrl_reg1;
	assign o_combined_mode = combined;
	assign o_device_reset = ctrl_reg1[`AHP_CR1_RESET_BIT];
endmodule
`default_nettype wire

//--- ahp_pkg.sv
// Types of the converter parallel host port
package ahp_pkg;
	// Access state, Gray coded along idle-read and idle-write paths
	typedef enum logic [1:0] {
		AHP_IDLE = 2'h0,
		AHP_READ = 2'h1,
		AHP_WRITE = 2'h2
	} ahp_state_t;
endpackage

//--- ahp_port_asserts.sv
// Concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
`include "ahp_regs.svh"
module ahp_port_chk (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_read_n,
	input wire logic i_store_n,
	input wire logic [`AHP_BUS_W-1:0] o_data,
	input wire logic o_data_oe,
	input wire logic o_result_ready_flag,
	input wire logic [`AHP_CTRL_W-1:0] o_ctrl_reg0,
	input wire logic [`AHP_CTRL_W-1:0] o_ctrl_reg1,
	input wire logic o_combined_mode,
	input wire logic [1:0] o_state
);
	import ahp_pkg::*;
	logic sel;
	logic rdq;
	logic wrq;
	// Pin-level qualifiers of both access kinds
	assign sel = !i_chip_sel_a_n && i_chip_sel_b;
	assign rdq = sel && i_store_n && (o_combined_mode || !i_read_n);
	assign wrq = sel && !i_store_n && (o_combined_mode || i_read_n);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	// Access opening: idle, then held through the sync chain
	sequence rd_begin;
		!rdq ##1 rdq [*3];
	endsequence
	sequence wr_begin;
		!wrq ##1 wrq [*3];
	endsequence
	rd_oe_a: assert property (o_data_oe |-> $past(rdq, 3))
		else $error("drivers on without read");
	oe_drop_a: assert property (!$past(rdq, 3) |-> !o_data_oe)
		else $error("drivers late off");
	rd_start_a: assert property (rd_begin |=> o_data_oe)
		else $error("read not started");
	rd_word_a: assert property (o_data_oe |-> o_data[11:10] == 2'h0)
		else $error("top data bits set");
	flag_drop_a: assert property ($rose(o_data_oe) |=> !o_result_ready_flag)
		else $error("flag not cleared");
	wr_start_a: assert property (wr_begin |=> o_state == AHP_WRITE)
		else $error("write not started");
	ctrl_load_a: assert property (($changed(o_ctrl_reg0) || $changed(o_ctrl_reg1))
		|-> $past(o_state) == AHP_WRITE)
		else $error("control changed outside write");
	mode_bit_a: assert property ($changed(o_combined_mode)
		|-> $past(o_state) == AHP_WRITE)
		else $error("mode changed outside write");
	rd_block_a: assert property (!i_store_n |-> ##3 !o_data_oe)
		else $error("read while store active");
	wr_block_a: assert property ((!o_combined_mode && !i_read_n)
		|-> ##3 o_state != AHP_WRITE)
		else $error("write while read strobe low");
endmodule
bind ahp_host_port ahp_port_chk i_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_chip_sel_a_n(i_chip_sel_a_n), .i_chip_sel_b(i_chip_sel_b), .i_read_n(i_read_n),
	.i_store_n(i_store_n), .o_data(o_data), .o_data_oe(o_data_oe),
	.o_result_ready_flag(o_result_ready_flag), .o_ctrl_reg0(o_ctrl_reg0),
	.o_ctrl_reg1(o_ctrl_reg1), .o_combined_mode(o_combined_mode), .o_state(o_state));
`default_nettype wire

//--- ahp_regs.svh
// Constants of the converter parallel host port
`ifndef AHP_REGS_SVH
`define AHP_REGS_SVH

// ---------------------------------------------------------------
// Bus and result widths
// ---------------------------------------------------------------
`define AHP_BUS_W 12
`define AHP_RESULT_W 10
`define AHP_CTRL_W 10
`define AHP_FIFO_DEPTH 16

// ---------------------------------------------------------------
// Control word layout
// ---------------------------------------------------------------
`define AHP_SEL_HI 11
`define AHP_SEL_LO 10
`define AHP_SEL_CR0 2'h0
`define AHP_SEL_CR1 2'h1
`define AHP_CR1_MODE_BIT 6
`define AHP_CR1_RESET_BIT 0
`define AHP_CR0_RESET 10'h000
`define AHP_CR1_RESET 10'h030

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define AHP_CLK_PERIOD_NS 10
`define AHP_FLAG_DELAY_NS 12
`define AHP_FLAG_DELAY_CYC ((`AHP_FLAG_DELAY_NS / `AHP_CLK_PERIOD_NS) < 1 ? 1 : \
	(`AHP_FLAG_DELAY_NS / `AHP_CLK_PERIOD_NS))
`define AHP_MIN_PULSE_NS 10

`endif

//--- ahp_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module ahp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	// ---------------------------------------------------------------
	// Synchroniser chain
	// ---------------------------------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			meta <= INIT;
			o_sync <= INIT;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire
